/* File: hw/alu_xfer_pkg.sv */
// Constants, types and helpers for the accumulator transfer ALU
package alu_xfer_pkg;
	localparam logic [2:0] CODE_MEM = 3'h6;
	localparam logic [2:0] CODE_ACC = 3'h7;
	localparam logic [2:0] CODE_B = 3'h0;
	localparam logic [2:0] CODE_C = 3'h1;
	localparam logic [2:0] CODE_D = 3'h2;
	localparam logic [2:0] CODE_E = 3'h3;
	localparam logic [2:0] CODE_H = 3'h4;
	localparam logic [2:0] CODE_L = 3'h5;
	localparam logic [1:0] GRP_MISC = 2'h0;
	localparam logic [1:0] GRP_COPY = 2'h1;
	localparam logic [1:0] GRP_ALU = 2'h2;
	localparam logic [7:0] OP_RAR = 8'h1F;
	localparam logic [2:0] LOW_PAIR_XFER = 3'h2;
	localparam int PAIR_SEL_BIT = 4;
	localparam int LOAD_BIT = 3;
	localparam int HIGH_BIT = 5;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [7:0] OFS_FLAGS = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h20;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int FLAG_SIGN = 7;
	localparam int FLAG_ZERO = 6;
	localparam int FLAG_AUX = 4;
	localparam int FLAG_PAR = 2;
	localparam int FLAG_ONE = 1;
	localparam int FLAG_CARRY = 0;

	typedef enum logic [2:0] {ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBB, ALU_AND, ALU_XOR, ALU_OR, ALU_CMP} alu_op_type;
	typedef enum {ST_IDLE, ST_MEM, ST_EXEC, ST_DONE} state_type;
	typedef struct packed {logic sign; logic zero; logic aux; logic parity; logic carry;} flags_type;
	typedef struct packed {logic [7:0] res; flags_type flags;} alu_out_type;
	typedef struct packed {logic rotate_right_thru_carry; logic copy; logic store_acc_indirect; logic load_acc_indirect; logic alu; logic memRd; logic memWr;} dec_type;
	typedef struct packed {logic valid; logic write; logic [15:0] addr; logic [7:0] wdata;} mem_req_type;
	typedef struct packed {
		logic awvalid; logic [7:0] awaddr; logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
		logic bready; logic arvalid; logic [7:0] araddr; logic rready;
	} axi_req_type;
	typedef struct packed {
		logic awready; logic wready; logic bvalid; logic [1:0] bresp;
		logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
	} axi_rsp_type;

	function automatic logic [2:0] source_field(logic [7:0] o);
		return o[2:0];
	endfunction
	function automatic logic [2:0] dest_field(logic [7:0] o);
		return o[5:3];
	endfunction

	// Opcode group decode, shared by the take and execute stages
	function automatic dec_type decode(logic [7:0] o);
		dec_type d;
		logic pair;
		d.rotate_right_thru_carry = (o == OP_RAR);
		d.copy = (o[7:6] == GRP_COPY);
		pair = (o[7:6] == GRP_MISC) && (source_field(o) == LOW_PAIR_XFER) && !o[HIGH_BIT];
		d.store_acc_indirect = pair && !o[LOAD_BIT];
		d.load_acc_indirect = pair && o[LOAD_BIT];
		d.alu = (o[7:6] == GRP_ALU);
		// Memory to memory copy is not valid code; it only runs a memory read here and writes nothing
		d.memRd = d.load_acc_indirect || ((d.copy || d.alu) && source_field(o) == CODE_MEM);
		d.memWr = d.store_acc_indirect || (d.copy && dest_field(o) == CODE_MEM && source_field(o) != CODE_MEM);
		return d;
	endfunction

	// Flag byte as software sees it at the flags register offset
	function automatic logic [7:0] flag_byte(flags_type f);
		logic [7:0] b;
		b = 8'h00;
		b[FLAG_SIGN] = f.sign;
		b[FLAG_ZERO] = f.zero;
		b[FLAG_AUX] = f.aux;
		b[FLAG_PAR] = f.parity;
		b[FLAG_ONE] = 1'b1;
		b[FLAG_CARRY] = f.carry;
		return b;
	endfunction

	// Eight accumulator operations; subtraction runs through the adder
	function automatic alu_out_type alu_calc(alu_op_type op, logic [7:0] a, logic [7:0] b, flags_type f);
		alu_out_type r;
		logic sub;
		logic arith;
		logic ci;
		logic [7:0] bb;
		logic [8:0] sum;
		logic [4:0] low;
		sub = (op == ALU_SUB) || (op == ALU_SBB) || (op == ALU_CMP);
		arith = (op == ALU_ADD) || (op == ALU_ADC) || sub;
		ci = ((op == ALU_ADC) || (op == ALU_SBB)) ? f.carry : 1'b0;
		bb = sub ? ~b : b;
		ci = sub ? ~ci : ci;
		sum = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
		low = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
		case (op)
			ALU_AND: r.res = a & b;
			ALU_XOR: r.res = a ^ b;
			ALU_OR: r.res = a | b;
			default: r.res = sum[7:0];
		endcase
		r.flags.sign = r.res[7];
		r.flags.zero = (r.res == 8'h00);
		r.flags.parity = ~^r.res;
		r.flags.carry = arith ? (sum[8] ^ sub) : 1'b0;
		r.flags.aux = arith ? (low[4] ^ sub) : f.aux;
		return r;
	endfunction
endpackage

/* File: hw/accumulator_transfer_alu.sv */
// Decode and datapath for rotate, copy, indirect load/store and accumulator ALU ops
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module accumulator_transfer_alu import alu_xfer_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire axi_req_type axiReq,
	output axi_rsp_type axiRsp,
	input wire logic opValid,
	input wire logic [7:0] opCode,
	output logic opReady,
	output logic opDone,
	output mem_req_type memReq,
	input wire logic memDone,
	input wire logic [7:0] memRdData
);
	logic [7:0] regs_q [0:7];
	flags_type flags_q;
	state_type state_q;
	logic [7:0] opc_q;
	logic [7:0] memData_q;
	logic opReady_q;
	logic opDone_q;
	mem_req_type memReq_q;
	axi_rsp_type axiRsp_q;
	logic [7:0] awAddr_q;
	logic [7:0] wByte_q;
	logic wLane_q;
	dec_type inDec;
	dec_type exDec;
	logic [15:0] inAddr;
	logic [7:0] inData;
	logic [7:0] srcVal;
	alu_out_type aluOut;
	logic axiWrEn;
	logic axiWrOk;
	logic wrMapped;
	logic rdMapped;
	logic [7:0] rdByte;

	assign axiRsp = axiRsp_q;
	assign opReady = opReady_q;
	assign opDone = opDone_q;
	assign memReq = memReq_q;

	// Incoming opcode: memory address and store data picked at take time
	always_comb begin
		inDec = decode(opCode);
		if ((inDec.copy || inDec.alu) && (source_field(opCode) == CODE_MEM || dest_field(opCode) == CODE_MEM)) begin
			inAddr = {regs_q[CODE_H], regs_q[CODE_L]};
		end else if (opCode[PAIR_SEL_BIT]) begin
			inAddr = {regs_q[CODE_D], regs_q[CODE_E]};
		end else begin
			inAddr = {regs_q[CODE_B], regs_q[CODE_C]};
		end
		inData = inDec.store_acc_indirect ? regs_q[CODE_ACC] : regs_q[source_field(opCode)];
	end

	// Held opcode: operand select and ALU result
	always_comb begin
		exDec = decode(opc_q);
		srcVal = (source_field(opc_q) == CODE_MEM) ? memData_q : regs_q[source_field(opc_q)];
		aluOut = alu_calc(alu_op_type'(dest_field(opc_q)), regs_q[CODE_ACC], srcVal, flags_q);
	end

	// Sequencing: take opcode, run memory cycle if needed, execute, report done
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			opc_q <= REG_RST;
			memData_q <= REG_RST;
			opReady_q <= 1'b1;
			opDone_q <= 1'b0;
			memReq_q <= '0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (opValid && opReady_q) begin
						opc_q <= opCode;
						opReady_q <= 1'b0;
						if (inDec.memRd || inDec.memWr) begin
							memReq_q <= '{valid: 1'b1, write: inDec.memWr, addr: inAddr, wdata: inData};
							state_q <= ST_MEM;
						end else begin
							state_q <= ST_EXEC;
						end
					end
				end
				ST_MEM: begin
					// Request holds until the memory answers; no timeout by design
					if (memDone) begin
						memReq_q.valid <= 1'b0;
						memData_q <= memRdData;
						state_q <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					opDone_q <= 1'b1;
					state_q <= ST_DONE;
				end
				ST_DONE: begin
					opDone_q <= 1'b0;
					opReady_q <= 1'b1;
					state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Register file and flags; execution owns them, software writes only while idle
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			for (int i = 0; i < 8; i++) begin
				regs_q[i] <= REG_RST;
			end
			flags_q <= '0;
		end else if (state_q == ST_EXEC) begin
			if (exDec.rotate_right_thru_carry) begin
				regs_q[CODE_ACC] <= {flags_q.carry, regs_q[CODE_ACC][7:1]};
				flags_q.carry <= regs_q[CODE_ACC][0];
			end
			if (exDec.copy && dest_field(opc_q) != CODE_MEM && source_field(opc_q) != CODE_MEM) begin
				regs_q[dest_field(opc_q)] <= srcVal;
			end
			if (exDec.copy && dest_field(opc_q) != CODE_MEM && source_field(opc_q) == CODE_MEM) begin
				regs_q[dest_field(opc_q)] <= memData_q;
			end
			if (exDec.load_acc_indirect) begin
				regs_q[CODE_ACC] <= memData_q;
			end
			if (exDec.alu) begin
				flags_q <= aluOut.flags;
				if (alu_op_type'(dest_field(opc_q)) != ALU_CMP) begin
					regs_q[CODE_ACC] <= aluOut.res;
				end
			end
		end else if (axiWrEn && axiWrOk && wLane_q) begin
			if (awAddr_q == OFS_FLAGS) begin
				flags_q <= '{sign: wByte_q[FLAG_SIGN], zero: wByte_q[FLAG_ZERO], aux: wByte_q[FLAG_AUX],
					parity: wByte_q[FLAG_PAR], carry: wByte_q[FLAG_CARRY]};
			end else if (awAddr_q != OFS_STATUS) begin
				regs_q[awAddr_q[4:2]] <= wByte_q;
			end
		end
	end

	// Bus decode; the status word is read only
	always_comb begin
		axiWrEn = !axiRsp_q.awready && !axiRsp_q.wready && !axiRsp_q.bvalid;
		wrMapped = (awAddr_q[1:0] == 2'h0) && (awAddr_q < OFS_STATUS);
		axiWrOk = wrMapped && (state_q == ST_IDLE);
		rdMapped = (axiReq.araddr[1:0] == 2'h0) && (axiReq.araddr <= OFS_STATUS);
		rdByte = (axiReq.araddr == OFS_FLAGS) ? flag_byte(flags_q) : regs_q[axiReq.araddr[4:2]];
	end

	// AXI4-Lite slave; address and data taken in either order, one of each at a time
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			axiRsp_q <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
			awAddr_q <= REG_RST;
			wByte_q <= REG_RST;
			wLane_q <= 1'b0;
		end else begin
			if (axiReq.awvalid && axiRsp_q.awready) begin
				awAddr_q <= axiReq.awaddr;
				axiRsp_q.awready <= 1'b0;
			end
			if (axiReq.wvalid && axiRsp_q.wready) begin
				wByte_q <= axiReq.wdata[7:0];
				wLane_q <= axiReq.wstrb[0];
				axiRsp_q.wready <= 1'b0;
			end
			if (axiWrEn) begin
				axiRsp_q.bvalid <= 1'b1;
				axiRsp_q.bresp <= axiWrOk ? RESP_OKAY : RESP_SLVERR;
			end
			if (axiRsp_q.bvalid && axiReq.bready) begin
				axiRsp_q.bvalid <= 1'b0;
				axiRsp_q.awready <= 1'b1;
				axiRsp_q.wready <= 1'b1;
			end
			if (axiReq.arvalid && axiRsp_q.arready) begin
				axiRsp_q.arready <= 1'b0;
				axiRsp_q.rvalid <= 1'b1;
				axiRsp_q.rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
				if (!rdMapped) begin
					axiRsp_q.rdata <= '0;
				end else if (axiReq.araddr == OFS_STATUS) begin
					axiRsp_q.rdata <= {16'h0000, opc_q, 7'h00, state_q != ST_IDLE};
				end else begin
					axiRsp_q.rdata <= {24'h000000, rdByte};
				end
			end
			if (axiRsp_q.rvalid && axiReq.rready) begin
				axiRsp_q.rvalid <= 1'b0;
				axiRsp_q.arready <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	AST_RAR_ROTATE: assert property ((state_q == ST_EXEC && exDec.rotate_right_thru_carry) |=>
		flags_q.carry == $past(regs_q[CODE_ACC][0]) && regs_q[CODE_ACC][7] == $past(flags_q.carry)
		&& flags_q.zero == $past(flags_q.zero)) else $error("rotate through carry wrong");
	AST_COPY_NO_FLAGS: assert property ((state_q == ST_EXEC && exDec.copy) |=>
		flags_q == $past(flags_q)) else $error("copy changed flags");
	AST_COPY_ACC_FROM_E: assert property ((state_q == ST_EXEC && opc_q == {GRP_COPY, CODE_ACC, CODE_E}) |=>
		regs_q[CODE_ACC] == $past(regs_q[CODE_E])) else $error("copy E to A wrong");
	AST_STORE_PAIR: assert property ((state_q == ST_IDLE && opValid && opReady_q && inDec.store_acc_indirect) |=>
		memReq_q.valid && memReq_q.write && memReq_q.wdata == $past(regs_q[CODE_ACC])
		&& memReq_q.addr == ($past(opCode[PAIR_SEL_BIT]) ? $past({regs_q[CODE_D], regs_q[CODE_E]})
		: $past({regs_q[CODE_B], regs_q[CODE_C]}))) else $error("indirect store address wrong");
	AST_LOAD_ACC: assert property ((state_q == ST_EXEC && exDec.load_acc_indirect) |=>
		regs_q[CODE_ACC] == $past(memData_q) && flags_q == $past(flags_q)) else $error("indirect load wrong");
	AST_ADD_CARRY: assert property ((state_q == ST_EXEC && exDec.alu && dest_field(opc_q) == 3'h0) |=>
		{flags_q.carry, regs_q[CODE_ACC]} == $past({1'b0, regs_q[CODE_ACC]} + {1'b0, srcVal}))
		else $error("add result or carry wrong");
	AST_LOGIC_CLEARS_CARRY: assert property ((state_q == ST_EXEC && exDec.alu && opc_q[5] && !(&opc_q[5:3])) |=>
		!flags_q.carry && flags_q.aux == $past(flags_q.aux)) else $error("logic op carry not cleared");
	AST_COMPARE_KEEPS: assert property ((state_q == ST_EXEC && exDec.alu && (&opc_q[5:3])) |=>
		regs_q[CODE_ACC] == $past(regs_q[CODE_ACC]) && flags_q.zero == ($past(srcVal) == $past(regs_q[CODE_ACC]))
		&& flags_q.carry == ($past(srcVal) > $past(regs_q[CODE_ACC]))) else $error("compare wrong");
	AST_MEM_OPERAND_HL: assert property ((state_q == ST_IDLE && opValid && opReady_q && inDec.alu
		&& source_field(opCode) == CODE_MEM) |=> memReq_q.addr == $past({regs_q[CODE_H], regs_q[CODE_L]}))
		else $error("memory operand address wrong");
	AST_FLAG_BYTE: assert property ((axiReq.arvalid && axiRsp_q.arready && axiReq.araddr == OFS_FLAGS) |=>
		axiRsp_q.rdata[7:0] == {$past(flags_q.sign), $past(flags_q.zero), 1'b0, $past(flags_q.aux), 1'b0,
		$past(flags_q.parity), 1'b1, $past(flags_q.carry)}) else $error("flag byte layout");
	AST_DONE_ONE_CYCLE: assert property ($rose(opDone_q) |=> !opDone_q ##1 opReady_q) else $error("done not a pulse");
endmodule

/* File: verification/mem_model.sv */
// Byte-wide memory partner that answers the block's memory requests
`timescale 1ns/1ps
module mem_model import alu_xfer_pkg::*; (
	input wire logic clk_sys,
	input wire mem_req_type memReq,
	input wire logic [3:0] delay,
	output logic memDone,
	output logic [7:0] memRdData
);
	logic [7:0] mem [logic [15:0]];
	logic [3:0] waitCnt;
	initial begin
		memDone = 1'b0;
		memRdData = 8'h5A;
		waitCnt = 4'h0;
	end
	// Answer after delay cycles; read data is only good in the done cycle
	always @(posedge clk_sys) begin
		memDone <= 1'b0;
		if (memReq.valid && !memDone) begin
			if (waitCnt == delay) begin
				waitCnt <= 4'h0;
				memDone <= 1'b1;
				if (memReq.write) mem[memReq.addr] = memReq.wdata;
				else memRdData <= mem[memReq.addr];
			end else begin
				waitCnt <= waitCnt + 4'h1;
			end
		end else begin
			memRdData <= ~memRdData; // Stale data keeps moving so it never looks valid
		end
	end
endmodule

/* File: verification/accumulator_transfer_alu_tb.sv */
// Self-checking bench for the accumulator transfer ALU
`timescale 1ns/1ps
module accumulator_transfer_alu_tb import alu_xfer_pkg::*;;
	logic clk_sys, rst_n, opValid, opReady, opDone, memDone;
	logic [7:0] opCode, memRdData, rdByte;
	logic [3:0] memDelay;
	logic [1:0] resp;
	logic [7:0] rv [8];
	logic [15:0] e;
	axi_req_type axiReq;
	axi_rsp_type axiRsp;
	mem_req_type memReq;
	int failures, check_count, cycles, i, j, op, p, c;
	logic [7:0] aV [3] = '{8'h62, 8'h0A, 8'h05};
	logic [7:0] bV [3] = '{8'hD4, 8'h0A, 8'h0C};
	logic [2:0] sV [3] = '{3'h0, 3'h7, 3'h6};
	accumulator_transfer_alu u_accumulator_transfer_alu (.clk_sys(clk_sys), .rst_n(rst_n), .axiReq(axiReq),
		.axiRsp(axiRsp), .opValid(opValid), .opCode(opCode), .opReady(opReady), .opDone(opDone),
		.memReq(memReq), .memDone(memDone), .memRdData(memRdData));
	mem_model u_mem_model (.clk_sys(clk_sys), .memReq(memReq), .delay(memDelay), .memDone(memDone),
		.memRdData(memRdData));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic stop_test();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Hang guard, well above the length of the whole sequence
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			stop_test();
		end
	end
	task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic axiWrite(input logic [7:0] a, input logic [7:0] d);
		logic aOk, wOk;
		aOk = 1'b0;
		wOk = 1'b0;
		@(posedge clk_sys);
		axiReq.awvalid <= 1'b1;
		axiReq.awaddr <= a;
		axiReq.wvalid <= 1'b1;
		axiReq.wdata <= {24'h000000, d};
		axiReq.wstrb <= 4'hF;
		axiReq.bready <= 1'b1;
		// Each channel is released only at the edge that takes it
		while (!(aOk && wOk)) begin
			@(posedge clk_sys);
			if (axiReq.awvalid && axiRsp.awready) begin
				aOk = 1'b1;
				axiReq.awvalid <= 1'b0;
			end
			if (axiReq.wvalid && axiRsp.wready) begin
				wOk = 1'b1;
				axiReq.wvalid <= 1'b0;
			end
		end
		do @(posedge clk_sys); while (!axiRsp.bvalid);
		resp = axiRsp.bresp;
		axiReq.bready <= 1'b0;
	endtask
	task automatic axiRead(input logic [7:0] a);
		@(posedge clk_sys);
		axiReq.arvalid <= 1'b1;
		axiReq.araddr <= a;
		axiReq.rready <= 1'b1;
		do @(posedge clk_sys); while (!axiRsp.arready);
		axiReq.arvalid <= 1'b0;
		do @(posedge clk_sys); while (!axiRsp.rvalid);
		rdByte = axiRsp.rdata[7:0];
		resp = axiRsp.rresp;
		axiReq.rready <= 1'b0;
	endtask
	task automatic rdChk(input string n, input logic [7:0] a, input logic [7:0] exp);
		axiRead(a);
		check(n, rdByte, exp);
	endtask
	// Offer one opcode, wait until taken, then until its done pulse
	task automatic runOp(input logic [7:0] o);
		@(posedge clk_sys);
		opValid <= 1'b1;
		opCode <= o;
		do @(posedge clk_sys); while (!opReady);
		opValid <= 1'b0;
		do @(posedge clk_sys); while (!opDone);
	endtask
	// Reference result and flag byte, worked out bit by bit
	function automatic logic [15:0] aluExp(input int o, input logic [7:0] a, input logic [7:0] b, input logic cy);
		logic [8:0] s;
		logic h, ci;
		ci = (o == 1 || o == 3) ? cy : 1'b0;
		h = cy;
		case (o)
			0, 1: begin
				s = a + b + ci;
				h = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + ci) > 5'h0F;
			end
			4: s = {1'b0, a & b};
			5: s = {1'b0, a ^ b};
			6: s = {1'b0, a | b};
			default: begin
				s = a - b - ci;
				h = {1'b0, a[3:0]} < ({1'b0, b[3:0]} + ci);
			end
		endcase
		return {(o == 7) ? a : s[7:0], s[7], s[7:0] == 8'h00, 1'b0, h, 1'b0, ~^s[7:0], 1'b1, s[8]};
	endfunction
	initial begin
		rst_n = 1'b0;
		axiReq = '0;
		opValid = 1'b0;
		opCode = 8'h00;
		memDelay = 4'h0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		for (i = 0; i < 8; i++) if (i != 6) rdChk("reset reg", 8'(i * 4), 8'h00);
		rdChk("reset flags", 8'h18, 8'h02);
		axiWrite(8'h1C, 8'h88);
		axiWrite(8'h18, 8'hD7);
		runOp(8'h1F);
		rdChk("rotate acc", 8'h1C, 8'hC4);
		rdChk("rotate flags", 8'h18, 8'hD6);
		for (i = 0; i < 8; i++) if (i != 6) begin
			rv[i] = 8'h30 + 8'(i);
			axiWrite(8'(i * 4), rv[i]);
		end
		// Chain of copies over every register code; memory to memory is never offered
		for (i = 0; i < 8; i++) if (i != 6) begin
			j = (i == 5) ? 7 : (i + 1) % 8;
			runOp({2'b01, 3'(i), 3'(j)});
			rv[i] = rv[j];
			rdChk("copy dest", 8'(i * 4), rv[i]);
			rdChk("copy source", 8'(j * 4), rv[j]);
		end
		runOp(8'h7B);
		rdChk("copy E to acc", 8'h1C, rv[3]);
		rv[7] = rv[3];
		rdChk("copy flags", 8'h18, 8'hD6);
		axiWrite(8'h10, 8'h12);
		axiWrite(8'h14, 8'h34);
		memDelay = 4'h3;
		runOp(8'h70);
		check("copy to memory", u_mem_model.mem[16'h1234], rv[0]);
		u_mem_model.mem[16'h1234] = 8'hA5;
		runOp(8'h4E);
		rdChk("copy from memory", 8'h04, 8'hA5);
		axiWrite(8'h00, 8'h20);
		axiWrite(8'h04, 8'h01);
		axiWrite(8'h08, 8'h20);
		axiWrite(8'h0C, 8'h02);
		axiWrite(8'h1C, 8'h5A);
		memDelay = 4'h0;
		runOp(8'h02);
		axiWrite(8'h1C, 8'h6B);
		memDelay = 4'h2;
		runOp(8'h12);
		check("store via BC", u_mem_model.mem[16'h2001], 8'h5A);
		check("store via DE", u_mem_model.mem[16'h2002], 8'h6B);
		u_mem_model.mem[16'h2002] = 8'hC3;
		runOp(8'h0A);
		rdChk("load via BC", 8'h1C, 8'h5A);
		runOp(8'h1A);
		rdChk("load via DE", 8'h1C, 8'hC3);
		rdChk("transfer flags", 8'h18, 8'hD6);
		// Every operation against a register, the accumulator itself and memory
		for (op = 0; op < 8; op++) for (p = 0; p < 3; p++) for (c = 0; c < 2; c++) begin
			axiWrite(8'h1C, aV[p]);
			axiWrite(8'h00, bV[p]);
			u_mem_model.mem[16'h1234] = bV[p];
			axiWrite(8'h18, (c == 1) ? 8'h13 : 8'h02);
			e = aluExp(op, aV[p], bV[p], c[0]);
			runOp({2'b10, 3'(op), sV[p]});
			rdChk("alu acc", 8'h1C, e[15:8]);
			rdChk("alu flags", 8'h18, e[7:0]);
			rdChk("alu operand", 8'h00, bV[p]);
		end
		axiRead(8'h24);
		check("unmapped read resp", {6'h00, resp}, {6'h00, RESP_SLVERR});
		axiWrite(8'h20, 8'h55);
		check("status write resp", {6'h00, resp}, {6'h00, RESP_SLVERR});
		stop_test();
	end
endmodule
